// *** pkg/ebs_pkg.sv ***
/*
 * Constants and types for the boot configuration and external bus select block.
 * Assumes a 16-bit CPU I/O port space and a 10 MHz core clock.
 */
package ebs_pkg;
    // register map
    localparam logic [15:0] EBS_SELECT_ADDR    = 16'h1c00;
    localparam logic [15:0] EBS_SELECT_RESET   = 16'h0000;
    localparam logic [15:0] EBS_SELECT_WMASK   = 16'h7f3f;
    localparam int          EBS_PARALLEL_PORT_MODE_LSB     = 12;
    localparam int          EBS_PARALLEL_PORT_MODE_MSB     = 14;
    localparam int          EBS_SERIAL_PORT1_MODE_LSB    = 10;
    localparam int          EBS_SERIAL_PORT1_MODE_MSB    = 11;
    localparam int          EBS_SERIAL_PORT0_MODE_LSB    = 8;
    localparam int          EBS_SERIAL_PORT0_MODE_MSB    = 9;
    localparam int          EBS_ADDRGPIO_LSB   = 0;
    localparam int          EBS_ADDRGPIO_MSB   = 5;
    localparam int          EBS_ADDR_PINS      = 6;
    localparam int          EBS_PP_PINS        = 21;

    // clock generator setting for the on-chip oscillator source
    localparam logic [10:0] EBS_PLL_MULT       = 11'h177;
    localparam logic [10:0] EBS_PLL_MULT_RESET = 11'h001;

    // boot peripheral query window
    localparam int          EBS_CLK_PERIOD_NS  = 100;
    localparam int          EBS_QUERY_TIME_US  = 100;
    localparam int          EBS_QUERY_CYCLES   =
        (EBS_QUERY_TIME_US * 1000) / EBS_CLK_PERIOD_NS;
    localparam int          EBS_BOOT_PERIPHS   = 6;
    localparam int          EBS_IDLE_DOMAINS   = 8;
    localparam int          EBS_CPU_DOMAIN     = 0;

    typedef enum logic [2:0] {
        EBS_ST_CLOCK = 3'b001,
        EBS_ST_QUERY = 3'b010,
        EBS_ST_DONE  = 3'b100
    } ebs_boot_state_type;
endpackage : ebs_pkg

// *** hdl/ebs_pin_route.sv ***
/*
 * Per-pin mux between memory-interface address and general-purpose I/O.
 * Assumes the select comes from the bus select register's next value.
 */
`timescale 1ns/1ns
module ebs_pin_route #(
    parameter int WIDTH = 6
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] gpioSelect,
    input  wire logic [WIDTH-1:0] emifAddrOut,
    input  wire logic [WIDTH-1:0] gpioOut,
    input  wire logic [WIDTH-1:0] gpioOe_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOe_n,
    output logic      [WIDTH-1:0] gpioIn
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            wire next_out;
            wire next_oe_n;
            wire next_in;
            // address lines are always driven while in memory function
            assign next_out  = gpioSelect[i] ? gpioOut[i] : emifAddrOut[i];
            assign next_oe_n = gpioSelect[i] ? gpioOe_n[i] : 1'b0;
            assign next_in   = gpioSelect[i] & pinIn[i];
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinOut[i]  <= 1'b0;
                    pinOe_n[i] <= 1'b1;
                    gpioIn[i]  <= 1'b0;
                end else begin
                    pinOut[i]  <= next_out; // R5
                    pinOe_n[i] <= next_oe_n;
                    gpioIn[i]  <= next_in;
                end
            end
        end
    endgenerate
endmodule : ebs_pin_route

// *** hdl/ebs_boot_config_and_bus_select.sv ***
/*
 * Reset-time straps, boot clock and peripheral clock sequencing, and the
 * external bus select register with its upper address pin routing.
 * Assumes CPU I/O strobes are one-cycle pulses synchronous to core_clk and
 * straps are tied statically on the board.
 */
`timescale 1ns/1ns
// Contract
// [R1] parallel_port_mode field routes peripherals onto the 21 parallel port pins.
// [R2] serial port mode fields pick audio serial or memory card per serial port.
// [R3] select register is readable and writable at I/O address 0x1C00.
// [R4] new routing applies on the clock cycle after the write.
// [R5] each upper address pin becomes GPIO when its select bit is 1.
// [R6] software gates affected peripheral clocks before writing the select register.
// [R7] software resets affected peripherals after changing the select register.
// [R8] bit 15 reads 0; mode fields at 14:12, 11:10, 9:8 reset to zero.
// [R9] bits 7:6 read 0; bits 5:0 are address GPIO selects resetting 0.
// [R10] clock strap picks oscillator or external clock for the clock generator.
// [R11] board ties the clock strap statically; it never changes in operation.
// [R12] regulator strap low: monitor makes power ok; high: power ok held high.
// [R13] a device reset follows any change of a strap pin's function.
// [R14] oscillator source: clock multiplied by 375; external source: generator bypassed.
// [R15] external clock is 11.2896, 12.0 or 12.288 MHz.
// [R16] boot image settings leave clock generator and boot timer alone.
// [R17] each peripheral clock on only while queried; all off and idled at hand-over.
// [R18] RAM block 31 reserved during boot, free for application afterwards.
// [R19] writes to reserved bit 15 have no effect; it reads its fixed value.
// [R20] select register keeps its reset value until software writes it.
module ebs_boot_config_and_bus_select
    import ebs_pkg::*;
#(
    parameter int NUM_PERIPHS  = EBS_BOOT_PERIPHS,
    parameter int QUERY_CYCLES = EBS_QUERY_CYCLES,
    parameter int IDLE_DOMAINS = EBS_IDLE_DOMAINS
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic [15:0]             ioAddr,
    input  wire logic                    ioWrite,
    input  wire logic                    ioRead,
    input  wire logic [15:0]             ioWriteData,
    output logic      [15:0]             ioReadData,
    output logic                         ioReadValid,
    input  wire logic                    clock_source_select_pin,
    input  wire logic                    core_regulator_enable_pin,
    input  wire logic                    monitorOk,
    output logic                         power_ok_signal,
    output logic                         genClockFromExt,
    output logic                         pllBypass,
    output logic      [10:0]             pllMultiplier,
    input  wire logic                    bootImageFound,
    output logic      [NUM_PERIPHS-1:0]  periphClockEnable,
    output logic      [IDLE_DOMAINS-1:0] idleDomainRequest,
    output logic                         sramBlock31Reserved,
    output logic                         bootDone,
    output logic      [2:0]              parallel_port_mode,
    output logic      [1:0]              serial_port1_mode,
    output logic      [1:0]              serial_port0_mode,
    output logic      [5:0]              upper_addr_pin_gpio_select,
    input  wire logic [5:0]              emifAddrOut,
    input  wire logic [5:0]              gpioOut,
    input  wire logic [5:0]              gpioOe_n,
    input  wire logic [5:0]              upperPinIn,
    output logic      [5:0]              upperPinOut,
    output logic      [5:0]              upperPinOe_n,
    output logic      [5:0]              upperGpioIn
);
    function automatic logic ebsHit(input logic [15:0] addr);
        ebsHit = (addr == EBS_SELECT_ADDR);
    endfunction : ebsHit

    localparam int QW = $clog2(QUERY_CYCLES + 1);
    localparam int PW = (NUM_PERIPHS > 1) ? $clog2(NUM_PERIPHS) : 1;

    logic [15:0]        external_bus_select_reg;
    logic               strapCaptured;
    logic               clkSelLatched;
    ebs_boot_state_type bootState;
    logic [QW-1:0]      queryCount;
    logic [PW-1:0]      queryIndex;

    // bus select register
    wire        selWrite  = ioWrite & ebsHit(ioAddr); // R3
    wire        selRead   = ioRead & ebsHit(ioAddr); // R3
    // reserved bits are masked so writes cannot reach them
    wire [15:0] next_select = selWrite ? (ioWriteData & EBS_SELECT_WMASK) // R19
                                       : external_bus_select_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            external_bus_select_reg <= EBS_SELECT_RESET; // R8 R9 R20
        end else begin
            external_bus_select_reg <= next_select; // R4
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ioReadData  <= 16'h0000;
            ioReadValid <= 1'b0;
        end else begin
            ioReadData  <= selRead ? (external_bus_select_reg & EBS_SELECT_WMASK)
                                   : 16'h0000; // R8 R9
            ioReadValid <= selRead;
        end
    end

    // fields leave straight from the register flops
    assign parallel_port_mode =
        external_bus_select_reg[EBS_PARALLEL_PORT_MODE_MSB:EBS_PARALLEL_PORT_MODE_LSB]; // R1
    assign serial_port1_mode =
        external_bus_select_reg[EBS_SERIAL_PORT1_MODE_MSB:EBS_SERIAL_PORT1_MODE_LSB]; // R2
    assign serial_port0_mode =
        external_bus_select_reg[EBS_SERIAL_PORT0_MODE_MSB:EBS_SERIAL_PORT0_MODE_LSB]; // R2
    assign upper_addr_pin_gpio_select =
        external_bus_select_reg[EBS_ADDRGPIO_MSB:EBS_ADDRGPIO_LSB]; // R5

    // next value feeds the pin flops so pins follow one cycle after the write
    ebs_pin_route #(
        .WIDTH (EBS_ADDR_PINS)
    ) u_pin_route (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .gpioSelect  (next_select[EBS_ADDRGPIO_MSB:EBS_ADDRGPIO_LSB]),
        .emifAddrOut (emifAddrOut),
        .gpioOut     (gpioOut),
        .gpioOe_n    (gpioOe_n),
        .pinIn       (upperPinIn),
        .pinOut      (upperPinOut),
        .pinOe_n     (upperPinOe_n),
        .gpioIn      (upperGpioIn)
    );

    // clock strap: caught once after reset release, not by the reset itself
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strapCaptured <= 1'b0;
            clkSelLatched <= 1'b0;
        end else if (!strapCaptured) begin
            strapCaptured <= 1'b1;
            clkSelLatched <= clock_source_select_pin; // R10 R11
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            genClockFromExt <= 1'b0;
            power_ok_signal <= 1'b0;
        end else begin
            genClockFromExt <= strapCaptured & clkSelLatched; // R10
            // the regulator strap is static, so it is read directly
            power_ok_signal <= core_regulator_enable_pin | monitorOk; // R12
        end
    end

    // boot sequencer
    wire queryEnd  = (queryCount == QW'(QUERY_CYCLES - 1));
    wire lastIndex = (queryIndex == PW'(NUM_PERIPHS - 1));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bootState  <= EBS_ST_CLOCK;
            queryCount <= '0;
            queryIndex <= '0;
        end else begin
            case (bootState)
                EBS_ST_CLOCK: begin
                    if (strapCaptured) begin
                        bootState <= EBS_ST_QUERY;
                    end
                end
                EBS_ST_QUERY: begin
                    if (bootImageFound) begin
                        bootState <= EBS_ST_DONE;
                    end else if (queryEnd) begin
                        queryCount <= '0;
                        // no image anywhere: keep searching, as the loop never gives up
                        queryIndex <= lastIndex ? '0 : queryIndex + PW'(1);
                    end else begin
                        queryCount <= queryCount + QW'(1);
                    end
                end
                EBS_ST_DONE: begin
                    bootState <= EBS_ST_DONE;
                end
                default: begin
                    bootState <= EBS_ST_CLOCK;
                end
            endcase
        end
    end

    // clock generator setting made once the strap is known
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pllBypass     <= 1'b1;
            pllMultiplier <= EBS_PLL_MULT_RESET;
        end else if (bootState == EBS_ST_CLOCK && strapCaptured) begin
            pllBypass     <= clkSelLatched; // R14
            pllMultiplier <= clkSelLatched ? EBS_PLL_MULT_RESET : EBS_PLL_MULT; // R14
        end
    end

    wire [NUM_PERIPHS-1:0] queryOneHot = NUM_PERIPHS'(1) << queryIndex;
    wire inQuery = (bootState == EBS_ST_QUERY) & ~bootImageFound;
    wire goneDone = (bootState == EBS_ST_DONE) |
                    ((bootState == EBS_ST_QUERY) & bootImageFound);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            periphClockEnable   <= '0;
            idleDomainRequest   <= '0;
            sramBlock31Reserved <= 1'b1;
            bootDone            <= 1'b0;
        end else begin
            periphClockEnable   <= inQuery ? queryOneHot : '0; // R17
            idleDomainRequest   <= goneDone ? ~(IDLE_DOMAINS'(1) << EBS_CPU_DOMAIN)
                                            : '0; // R17
            sramBlock31Reserved <= ~goneDone; // R18
            bootDone            <= goneDone;
        end
    end

    // checks
    logic selWritten;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            selWritten <= 1'b0;
        end else if (selWrite) begin
            selWritten <= 1'b1;
        end
    end

    chk_reserved_read: assert property (@(posedge core_clk) disable iff (!reset_n) // R8 R9 R19
        ioReadValid |-> (ioReadData[15] == 1'b0 && ioReadData[7:6] == 2'b00))
        else $error("reserved select bits read nonzero");

    chk_write_route: assert property (@(posedge core_clk) disable iff (!reset_n) // R4 R1
        selWrite |=> (parallel_port_mode == $past(ioWriteData[14:12])))
        else $error("parallel port mode not applied after write");

    chk_serial_modes: assert property (@(posedge core_clk) disable iff (!reset_n) // R2
        selWrite |=> (serial_port1_mode == $past(ioWriteData[11:10])
                      && serial_port0_mode == $past(ioWriteData[9:8])))
        else $error("serial port modes not applied after write");

    chk_addr_decode: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        (ioWrite && ioAddr != EBS_SELECT_ADDR) |=> $stable(external_bus_select_reg))
        else $error("select register changed by foreign address");

    chk_read_back: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        (selRead && !selWrite) |=> (ioReadValid && ioReadData == $past(external_bus_select_reg)))
        else $error("select register read back wrong");

    chk_gpio_pin: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        ##1 (upper_addr_pin_gpio_select[0] == 1'b0) |-> (upperPinOe_n[0] == 1'b0))
        else $error("address pin not driven in memory function");

    chk_reset_value: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
        !selWritten |-> (external_bus_select_reg == EBS_SELECT_RESET))
        else $error("select register left reset value without a write");

    chk_power_ok: assert property (@(posedge core_clk) disable iff (!reset_n) // R12
        core_regulator_enable_pin |=> power_ok_signal)
        else $error("power ok not held high with regulator strap high");

    chk_pll_setting: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
        (bootState == EBS_ST_QUERY && !clkSelLatched) |-> (pllMultiplier == EBS_PLL_MULT && !pllBypass))
        else $error("clock generator not set to 375 on oscillator source");

    chk_clock_source: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
        (bootState == EBS_ST_QUERY) |-> (genClockFromExt == clkSelLatched))
        else $error("clock generator source does not follow strap");

    chk_handover_gated: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
        bootDone |-> (periphClockEnable == '0 && idleDomainRequest[EBS_CPU_DOMAIN] == 1'b0
                      && &(idleDomainRequest | (IDLE_DOMAINS'(1) << EBS_CPU_DOMAIN))))
        else $error("peripheral clocks or idle domains wrong at hand-over");

    chk_one_clock: assert property (@(posedge core_clk) disable iff (!reset_n) // R17
        $onehot0(periphClockEnable))
        else $error("more than one peripheral clock open during boot");

    chk_sram_reserved: assert property (@(posedge core_clk) disable iff (!reset_n) // R18
        sramBlock31Reserved != bootDone)
        else $error("RAM block 31 reservation disagrees with boot state");

    cov_select_write: cover property (@(posedge core_clk) disable iff (!reset_n)
        selWrite ##1 selRead);
    cov_gpio_mode: cover property (@(posedge core_clk) disable iff (!reset_n)
        upper_addr_pin_gpio_select == 6'h3f);
    cov_boot_done: cover property (@(posedge core_clk) disable iff (!reset_n)
        $rose(bootDone));
    cov_query_wrap: cover property (@(posedge core_clk) disable iff (!reset_n)
        inQuery && queryEnd && lastIndex);
endmodule : ebs_boot_config_and_bus_select

// *** test/ebs_boot_config_and_bus_select_bench.sv ***
/*
 * Self-checking bench for the boot configuration and external bus select block.
 * Assumes the block's own I/O strobe protocol and a short query window (4 cycles).
 */
`timescale 1ns/1ns
module ebs_boot_config_and_bus_select_bench;
    import ebs_pkg::*;
    localparam int QCYC = 4;
    localparam logic [15:0] ADDR = EBS_SELECT_ADDR;
    logic        core_clk, reset_n, ioWrite, ioRead, ioReadValid;
    logic [15:0] ioAddr, ioWriteData, ioReadData;
    logic        clock_source_select_pin, core_regulator_enable_pin, monitorOk;
    logic        power_ok_signal, genClockFromExt, pllBypass, bootImageFound;
    logic        sramBlock31Reserved, bootDone;
    logic [10:0] pllMultiplier;
    logic [5:0]  periphClockEnable;
    logic [7:0]  idleDomainRequest;
    logic [2:0]  parallel_port_mode;
    logic [1:0]  serial_port1_mode, serial_port0_mode;
    logic [5:0]  upper_addr_pin_gpio_select, emifAddrOut, gpioOut, gpioOe_n, upperPinIn;
    logic [5:0]  upperPinOut, upperPinOe_n, upperGpioIn;
    int          failures, checked, n;
    logic [15:0] rd;
    logic        ok;

    ebs_boot_config_and_bus_select #(.QUERY_CYCLES(QCYC)) u_ebs_boot_config_and_bus_select (
        .core_clk(core_clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWriteData(ioWriteData), .ioReadData(ioReadData),
        .ioReadValid(ioReadValid), .clock_source_select_pin(clock_source_select_pin),
        .core_regulator_enable_pin(core_regulator_enable_pin), .monitorOk(monitorOk),
        .power_ok_signal(power_ok_signal), .genClockFromExt(genClockFromExt),
        .pllBypass(pllBypass), .pllMultiplier(pllMultiplier), .bootImageFound(bootImageFound),
        .periphClockEnable(periphClockEnable), .idleDomainRequest(idleDomainRequest),
        .sramBlock31Reserved(sramBlock31Reserved), .bootDone(bootDone),
        .parallel_port_mode(parallel_port_mode), .serial_port1_mode(serial_port1_mode),
        .serial_port0_mode(serial_port0_mode),
        .upper_addr_pin_gpio_select(upper_addr_pin_gpio_select), .emifAddrOut(emifAddrOut),
        .gpioOut(gpioOut), .gpioOe_n(gpioOe_n), .upperPinIn(upperPinIn),
        .upperPinOut(upperPinOut), .upperPinOe_n(upperPinOe_n), .upperGpioIn(upperGpioIn));

    always #50 core_clk = ~core_clk;

    task automatic stop_test();
        $display("counts: %0d comparisons, %0d mismatches", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check_value

    task automatic check_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: flag %h expected %h", $time, got, exp);
        end
    endtask : check_flag

    task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
        @(negedge core_clk);
        ioAddr = addr;
        ioWriteData = data;
        ioWrite = 1'b1;
        @(negedge core_clk);
        ioWrite = 1'b0;
    endtask : reg_write

    // valid may only come from a select read; wait is bounded either way
    task automatic reg_read(input logic [15:0] addr, output logic [15:0] data, output logic hit);
        @(negedge core_clk);
        ioAddr = addr;
        ioRead = 1'b1;
        @(negedge core_clk);
        ioRead = 1'b0;
        hit = 1'b0;
        data = 16'h0000;
        for (int i = 0; i < 3 && !hit; i++) begin
            if (ioReadValid === 1'b1) begin
                hit = 1'b1;
                data = ioReadData;
            end else
                @(negedge core_clk);
        end
    endtask : reg_read

    task automatic check_read(input logic [15:0] exp);
        reg_read(ADDR, rd, ok);
        check_flag(ok, 1'b1);
        check_value(rd, exp);
    endtask : check_read

    // the clock strap only changes under reset, as the board is expected to do
    task automatic do_reset(input logic clkSel);
        @(negedge core_clk);
        reset_n = 1'b0;
        clock_source_select_pin = clkSel;
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        n = 0;
        while (periphClockEnable !== 6'h01 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 10) begin
            failures++;
            $display("wrong value at %0t ns: boot query never started", $time);
            stop_test();
        end
    endtask : do_reset

    // expected select comes from the value written, not from the block
    task automatic check_pins(input logic [5:0] sel);
        @(negedge core_clk);
        check_value(16'(upperPinOut), 16'((gpioOut & sel) | (emifAddrOut & ~sel)));
        check_value(16'(upperPinOe_n), 16'(gpioOe_n & sel));
        check_value(16'(upperGpioIn & sel), 16'(upperPinIn & sel));
    endtask : check_pins

    initial begin
        core_clk = 1'b0; reset_n = 1'b0; ioAddr = 16'h0000; ioWriteData = 16'h0000;
        ioWrite = 1'b0; ioRead = 1'b0; clock_source_select_pin = 1'b0;
        core_regulator_enable_pin = 1'b0; monitorOk = 1'b0; bootImageFound = 1'b0;
        emifAddrOut = 6'h2a; gpioOut = 6'h15; gpioOe_n = 6'h0c; upperPinIn = 6'h33;
        failures = 0; checked = 0;

        do_reset(1'b0);
        check_value(16'(pllMultiplier), 16'h0177);
        check_flag(pllBypass, 1'b0);
        check_flag(genClockFromExt, 1'b0);
        check_flag(sramBlock31Reserved, 1'b1);
        check_value(16'(idleDomainRequest), 16'h0000);
        n = 0;
        while (periphClockEnable === 6'h01 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check_value(16'(n), 16'(QCYC));
        check_value(16'(periphClockEnable), 16'h0002);
        bootImageFound = 1'b1;
        @(negedge core_clk);
        bootImageFound = 1'b0;
        check_value(16'(periphClockEnable), 16'h0000);
        check_value(16'(idleDomainRequest), 16'h00fe);
        check_flag(bootDone, 1'b1);
        check_flag(sramBlock31Reserved, 1'b0);
        check_value(16'(pllMultiplier), 16'h0177);
        $display("test boot sequence done");

        check_value(16'(periphClockEnable), 16'h0000);
        check_read(16'h0000);
        check_pins(6'h00);
        reg_write(ADDR, 16'hffff);
        check_read(16'h7f3f);
        for (int m = 0; m < 8; m++) begin
            reg_write(ADDR, 16'((m << 12) | ((m % 4) << 10) | ((3 - m % 4) << 8)));
            check_value(16'(parallel_port_mode), 16'(m));
            check_value(16'(serial_port1_mode), 16'(m % 4));
            check_value(16'(serial_port0_mode), 16'(3 - m % 4));
        end
        reg_write(16'h1c01, 16'h0000);
        check_read(16'h7c00);
        reg_read(16'h1c02, rd, ok);
        check_flag(ok, 1'b0);
        $display("test register access done");

        reg_write(ADDR, 16'h0003);
        check_value(16'(upper_addr_pin_gpio_select), 16'h0003);
        check_pins(6'h03);
        emifAddrOut = 6'h1c;
        reg_write(ADDR, 16'h003c);
        check_pins(6'h3c);
        $display("test upper address pins done");

        for (int i = 0; i < 4; i++) begin
            core_regulator_enable_pin = i[1];
            monitorOk = i[0];
            @(negedge core_clk);
            check_flag(power_ok_signal, i[1] | i[0]);
        end
        core_regulator_enable_pin = 1'b0;
        $display("test power monitor done");

        do_reset(1'b1);
        check_flag(genClockFromExt, 1'b1);
        check_flag(pllBypass, 1'b1);
        check_value(16'(pllMultiplier), 16'h0001);
        check_read(16'h0000);
        $display("test external clock strap done");
        stop_test();
    end
endmodule : ebs_boot_config_and_bus_select_bench
